// ==== logic/temp_monitor_pkg.sv ====
// Function
// R01 - critical pin pulls low when any result reaches its critical limit
// R02 - no register bit can mask or gate the critical pin
// R03 - with strap enabled, bus address comes from the critical pin pull-up
// R04 - warning pin asserts on threshold crossing and can be masked
// R05 - result above high limit sets channel high status and warning
// R06 - result at or below low limit sets channel low status and warning
// R07 - result is 11 bits: high byte, then three bits in low byte 7:5
// R08 - unused five low bits of the result low byte read zero
// R09 - default range after reset: unsigned 0 to 127.875 in 0.125 steps
// R10 - extended range: unsigned, temperature plus 64, spanning -64 to 191
// R11 - default range saturates to zero below and 0x3FF above
// R12 - extended range saturates to zero below -64 and 0x7FF above
// R13 - host programs limits in the encoding of the selected range
// R14 - a limit at two addresses is fully usable at both, same storage
// R15 - new limits take effect only when the next conversion starts
// R16 - one internal plus four external channels, each with own limits
// R17 - reading high status clears it and the summary high bit
// R18 - warning waits for the programmed count of consecutive bad cycles
// R19 - critical pin holds until all results drop below limit minus hysteresis
// R20 - global mask deasserts warning and holds it until cleared
// R21 - compare the full 11-bit result at each channel conversion end
package temp_monitor_pkg;
  localparam int NUM_CH = 5;
  localparam int RES_W = 11;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_DEVICE_SETUP = 8'h03;
  localparam logic [7:0] REG_HIGH_STAT = 8'h04;
  localparam logic [7:0] REG_LOW_STAT = 8'h05;
  localparam logic [7:0] REG_CRIT_STAT = 8'h06;
  localparam logic [7:0] REG_CONSEC = 8'h07;
  localparam logic [7:0] REG_HYST = 8'h08;
  localparam logic [7:0] REG_SINGLE_CONV = 8'h0F;
  localparam logic [7:0] BASE_RES_HI = 8'h10;
  localparam logic [7:0] BASE_RES_LO = 8'h18;
  localparam logic [7:0] BASE_HIGH_HI = 8'h20;
  localparam logic [7:0] BASE_HIGH_LO = 8'h28;
  localparam logic [7:0] BASE_LOW_HI = 8'h30;
  localparam logic [7:0] BASE_LOW_LO = 8'h38;
  localparam logic [7:0] BASE_CRIT = 8'h40;
  localparam logic [7:0] BASE_HIGH_ALIAS = 8'h50;
  localparam logic [7:0] BASE_LOW_ALIAS = 8'h58;
  localparam int SETUP_MASK_BIT = 7;
  localparam int SETUP_STANDBY_BIT = 6;
  localparam int SETUP_RANGE_BIT = 2;
  localparam int STAT_HIGH_BIT = 4;
  localparam int STAT_LOW_BIT = 3;
  localparam int STAT_CRIT_BIT = 1;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] HYST_RESET = 8'h0A;
  localparam logic [2:0] CONSEC_RESET = 3'h0;
  localparam logic [10:0] HIGH_LIM_RESET = 11'h2A8;
  localparam logic [10:0] LOW_LIM_RESET = 11'h000;
  localparam logic [7:0] CRIT_RESET = 8'h55;
  localparam logic [6:0] DEFAULT_ADDR = 7'h4C;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic signed [13:0] EXT_OFFSET = 14'sh0200;
  localparam logic signed [13:0] DEF_FULL = 14'sh03FF;
  localparam logic signed [13:0] EXT_FULL = 14'sh07FF;
  localparam logic [3:0] K_NONE = 4'h0;
  localparam logic [3:0] K_RES_HI = 4'h1;
  localparam logic [3:0] K_RES_LO = 4'h2;
  localparam logic [3:0] K_HIGH_HI = 4'h3;
  localparam logic [3:0] K_HIGH_LO = 4'h4;
  localparam logic [3:0] K_LOW_HI = 4'h5;
  localparam logic [3:0] K_LOW_LO = 4'h6;
  localparam logic [3:0] K_CRIT = 4'h7;

  typedef struct packed {
    logic [2:0] chan;
    logic signed [12:0] temp;
    logic last;
  } meas_type;

  typedef struct packed {
    logic [3:0] kind;
    logic [2:0] chan;
  } reg_sel_type;

  typedef enum logic [3:0] {
    bus_idle = 4'h0,
    bus_addr = 4'h1,
    bus_ack = 4'h3,
    bus_ptr = 4'h2,
    bus_wdata = 4'h6,
    bus_rdata = 4'h7,
    bus_rack = 4'h5
  } bus_state_type;

  function automatic logic [6:0] strap_addr(input logic [2:0] code);
    case (code)
      3'h0: return 7'h7C;
      3'h1: return 7'h5C;
      3'h2: return 7'h4C;
      3'h3: return 7'h6C;
      3'h4: return 7'h1C;
      3'h5: return 7'h3C;
      default: return DEFAULT_ADDR;
    endcase
  endfunction : strap_addr

  function automatic logic [10:0] format_temp(input logic signed [12:0] t, input logic ext);
    logic signed [13:0] v;
    logic signed [13:0] full;
    v = $signed({t[12], t}) + (ext ? EXT_OFFSET : 14'sh0000);
    full = ext ? EXT_FULL : DEF_FULL;
    if (v < 14'sh0000)
      return 11'h000;
    else if (v > full)
      return full[10:0];
    else
      return v[10:0];
  endfunction : format_temp

  function automatic reg_sel_type decode_reg(input logic [7:0] a);
    reg_sel_type s;
    s.chan = a[2:0];
    s.kind = K_NONE;
    if (a[2:0] < 3'(NUM_CH))
    begin
      case (a[7:3])
        BASE_RES_HI[7:3]: s.kind = K_RES_HI;
        BASE_RES_LO[7:3]: s.kind = K_RES_LO;
        BASE_HIGH_HI[7:3], BASE_HIGH_ALIAS[7:3]: s.kind = K_HIGH_HI;
        BASE_HIGH_LO[7:3]: s.kind = K_HIGH_LO;
        BASE_LOW_HI[7:3], BASE_LOW_ALIAS[7:3]: s.kind = K_LOW_HI;
        BASE_LOW_LO[7:3]: s.kind = K_LOW_LO;
        BASE_CRIT[7:3]: s.kind = K_CRIT;
        default: s.kind = K_NONE;
      endcase
    end
    return s;
  endfunction : decode_reg
endpackage : temp_monitor_pkg

// ==== logic/temp_result_limit_compare.sv ====
`timescale 1ns/1ps
module temp_result_limit_compare
  import temp_monitor_pkg::*;
(
  input wire logic clk, // system clock, 200 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic scl_in, // serial clock pin level
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data drive value (always low)
  output logic sda_oe, // serial data pulled low while high
  input wire logic addr_strap_en, // strap address option enabled
  input wire logic [2:0] addr_strap_code, // sensed pull-up class on critical pin
  input wire logic meas_valid, // one channel conversion finished
  input wire meas_type meas, // channel, raw temperature, last of cycle
  output logic conv_start, // pulse: begin a conversion cycle
  output logic conv_standby, // device in standby
  output logic crit_out, // critical pin drive value (always low)
  output logic crit_oe, // critical pin pulled low while high
  output logic maskable_warning_out, // warning pin drive value (always low)
  output logic maskable_warning_oe // warning pin pulled low while high
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_prev;
  logic sda_prev;
  logic [1:0] strap_en_sync;
  logic [2:0] strap_code_sync [2];
  logic [1:0] strap_cnt;
  logic [6:0] dev_addr;
  bus_state_type state;
  bus_state_type ack_next;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] ptr;
  logic rw;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_take;
  logic [7:0] rd_addr;
  logic [7:0] device_setup;
  logic [7:0] hyst;
  logic [2:0] consec_limit;
  logic [10:0] result [NUM_CH];
  logic [10:0] high_lim [NUM_CH];
  logic [10:0] low_lim [NUM_CH];
  logic [7:0] crit_lim [NUM_CH];
  logic [10:0] high_act [NUM_CH];
  logic [10:0] low_act [NUM_CH];
  logic [7:0] crit_act [NUM_CH];
  logic [NUM_CH-1:0] high_stat;
  logic [NUM_CH-1:0] low_stat;
  logic [NUM_CH-1:0] crit_hot;
  logic busy;
  logic single_pend;
  logic cycle_bad;
  logic [3:0] consec;
  logic warn_active;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic ext_range;
  logic mask_all;
  logic [10:0] meas_res;
  logic [11:0] crit11;
  logic [11:0] release_lvl;
  logic meas_ok;
  logic over_high;
  logic under_low;
  logic at_crit;
  logic below_release;
  logic next_conv;
  logic [7:0] rd_byte;
  reg_sel_type rd_sel;
  reg_sel_type wr_sel;

  assign sda_out = 1'b0;
  assign crit_out = 1'b0;
  assign maskable_warning_out = 1'b0;
  assign ext_range = device_setup[SETUP_RANGE_BIT];
  assign mask_all = device_setup[SETUP_MASK_BIT];
  assign conv_standby = device_setup[SETUP_STANDBY_BIT];

  // pin synchronisers; only the second stage is read
  always_ff @(posedge clk)
  begin
    scl_sync <= {scl_sync[0], scl_in};
    sda_sync <= {sda_sync[0], sda_in};
    scl_prev <= scl_sync[1];
    sda_prev <= sda_sync[1];
    strap_en_sync <= {strap_en_sync[0], addr_strap_en};
    strap_code_sync[0] <= addr_strap_code;
    strap_code_sync[1] <= strap_code_sync[0];
  end

  assign scl_rise = scl_sync[1] & ~scl_prev;
  assign scl_fall = ~scl_sync[1] & scl_prev;
  assign start_cond = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign stop_cond = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

  // R03 strap address capture
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      strap_cnt <= 2'h0;
      dev_addr <= DEFAULT_ADDR;
    end
    else if (strap_cnt != STRAP_WAIT)
    begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == STRAP_WAIT - 2'h1)
        dev_addr <= strap_en_sync[1] ? strap_addr(strap_code_sync[1]) : DEFAULT_ADDR;
    end
  end

  assign rd_sel = decode_reg(ptr);
  assign wr_sel = decode_reg(wr_addr);

  always_comb
  begin
    rd_byte = 8'h00;
    unique case (rd_sel.kind)
      // R07 result byte split
      K_RES_HI: rd_byte = result[rd_sel.chan][10:3];
      // R08 low bits zero
      K_RES_LO: rd_byte = {result[rd_sel.chan][2:0], 5'h00};
      K_HIGH_HI: rd_byte = high_lim[rd_sel.chan][10:3];
      K_HIGH_LO: rd_byte = {high_lim[rd_sel.chan][2:0], 5'h00};
      K_LOW_HI: rd_byte = low_lim[rd_sel.chan][10:3];
      K_LOW_LO: rd_byte = {low_lim[rd_sel.chan][2:0], 5'h00};
      K_CRIT: rd_byte = crit_lim[rd_sel.chan];
      K_NONE:
      begin
        case (ptr)
          REG_STATUS: rd_byte = {3'h0, |high_stat, |low_stat, 1'b0, |crit_hot, 1'b0};
          REG_DEVICE_SETUP: rd_byte = device_setup;
          REG_HIGH_STAT: rd_byte = 8'(high_stat);
          REG_LOW_STAT: rd_byte = 8'(low_stat);
          REG_CRIT_STAT: rd_byte = 8'(crit_hot);
          REG_CONSEC: rd_byte = {5'h00, consec_limit};
          REG_HYST: rd_byte = hyst;
          default: rd_byte = 8'h00;
        endcase
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // serial bus target
  always_ff @(posedge clk)
  begin
    wr_stb <= 1'b0;
    rd_take <= 1'b0;
    if (rst || stop_cond)
    begin
      state <= bus_idle;
      sda_oe <= 1'b0;
      bit_cnt <= 4'h0;
    end
    else if (start_cond)
    begin
      state <= bus_addr;
      sda_oe <= 1'b0;
      bit_cnt <= 4'h0;
    end
    else if (scl_rise)
    begin
      if (state == bus_addr || state == bus_ptr || state == bus_wdata)
      begin
        shreg <= {shreg[6:0], sda_sync[1]};
        bit_cnt <= bit_cnt + 4'h1;
      end
      else if (state == bus_rack)
        rw <= ~sda_sync[1];
    end
    else if (scl_fall)
    begin
      unique case (state)
        bus_idle: sda_oe <= 1'b0;
        bus_addr:
          if (bit_cnt == 4'h8)
          begin
            if (shreg[7:1] == dev_addr)
            begin
              rw <= shreg[0];
              ack_next <= shreg[0] ? bus_rdata : bus_ptr;
              sda_oe <= 1'b1;
              state <= bus_ack;
            end
            else
              state <= bus_idle;
          end
        bus_ptr, bus_wdata:
          if (bit_cnt == 4'h8)
          begin
            if (state == bus_ptr)
              ptr <= shreg;
            else
            begin
              wr_stb <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr <= ptr + 8'h01;
            end
            ack_next <= bus_wdata;
            sda_oe <= 1'b1;
            state <= bus_ack;
          end
        bus_ack, bus_rack:
        begin
          bit_cnt <= 4'h0;
          if (ack_next == bus_rdata && rw)
          begin
            shreg <= {rd_byte[6:0], 1'b0};
            sda_oe <= ~rd_byte[7];
            rd_take <= 1'b1;
            rd_addr <= ptr;
            ptr <= ptr + 8'h01;
            bit_cnt <= 4'h1;
            state <= bus_rdata;
          end
          else
          begin
            sda_oe <= 1'b0;
            state <= (state == bus_rack) ? bus_idle : ack_next;
          end
        end
        bus_rdata:
          if (bit_cnt == 4'h8)
          begin
            sda_oe <= 1'b0;
            ack_next <= bus_rdata;
            state <= bus_rack;
          end
          else
          begin
            sda_oe <= ~shreg[7];
            shreg <= {shreg[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
        default: state <= bus_idle;
      endcase
    end
  end

  // R14 programmed limits, aliases share storage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      device_setup <= SETUP_RESET;
      hyst <= HYST_RESET;
      consec_limit <= CONSEC_RESET;
      for (int i = 0; i < NUM_CH; i++)
      begin
        high_lim[i] <= HIGH_LIM_RESET;
        low_lim[i] <= LOW_LIM_RESET;
        crit_lim[i] <= CRIT_RESET;
      end
    end
    else if (wr_stb)
    begin
      unique case (wr_sel.kind)
        K_HIGH_HI: high_lim[wr_sel.chan][10:3] <= wr_data;
        K_HIGH_LO: high_lim[wr_sel.chan][2:0] <= wr_data[7:5];
        K_LOW_HI: low_lim[wr_sel.chan][10:3] <= wr_data;
        K_LOW_LO: low_lim[wr_sel.chan][2:0] <= wr_data[7:5];
        K_CRIT: crit_lim[wr_sel.chan] <= wr_data;
        K_RES_HI, K_RES_LO: ;
        K_NONE:
        begin
          if (wr_addr == REG_DEVICE_SETUP)
            device_setup <= wr_data;
          if (wr_addr == REG_HYST)
            hyst <= wr_data;
          if (wr_addr == REG_CONSEC)
            consec_limit <= wr_data[2:0];
        end
        default: ;
      endcase
    end
  end

  // R15 conversion start and limit activation
  assign next_conv = ~busy & (~conv_standby | single_pend);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      single_pend <= 1'b0;
      conv_start <= 1'b0;
    end
    else
    begin
      conv_start <= next_conv;
      if (next_conv)
        busy <= 1'b1;
      else if (meas_valid && meas.last)
        busy <= 1'b0;
      if (next_conv)
        single_pend <= 1'b0;
      else if (wr_stb && wr_addr == REG_SINGLE_CONV && conv_standby)
        single_pend <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        high_act[i] <= HIGH_LIM_RESET;
        low_act[i] <= LOW_LIM_RESET;
        crit_act[i] <= CRIT_RESET;
      end
    end
    else if (next_conv)
    begin
      high_act <= high_lim;
      low_act <= low_lim;
      crit_act <= crit_lim;
    end
  end

  // R09 R10 R11 R12 range formatting with saturation
  assign meas_res = format_temp(meas.temp, ext_range);
  assign meas_ok = meas_valid && meas.chan < 3'(NUM_CH);
  // R21 full width compares
  assign over_high = meas_res > high_act[meas.chan];
  assign under_low = meas_res <= low_act[meas.chan];
  assign crit11 = {1'b0, crit_act[meas.chan], 3'h0};
  assign release_lvl = crit11 - {1'b0, hyst, 3'h0};
  assign at_crit = {1'b0, meas_res} >= crit11;
  assign below_release = (crit11 >= {1'b0, hyst, 3'h0}) && ({1'b0, meas_res} < release_lvl);

  // R16 per-channel result and status
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      high_stat <= '0;
      low_stat <= '0;
      crit_hot <= '0;
      for (int i = 0; i < NUM_CH; i++)
        result[i] <= 11'h000;
    end
    else
    begin
      // R17 read clears high status; a new event wins
      if (rd_take && rd_addr == REG_HIGH_STAT)
        high_stat <= '0;
      if (rd_take && rd_addr == REG_LOW_STAT)
        low_stat <= '0;
      if (meas_ok)
      begin
        result[meas.chan] <= meas_res;
        // R05 high status
        if (over_high)
          high_stat[meas.chan] <= 1'b1;
        // R06 low status
        if (under_low)
          low_stat[meas.chan] <= 1'b1;
        // R01 R19 critical set and hysteresis release
        if (at_crit)
          crit_hot[meas.chan] <= 1'b1;
        else if (below_release)
          crit_hot[meas.chan] <= 1'b0;
      end
    end
  end

  // R18 consecutive out-of-limit cycles
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cycle_bad <= 1'b0;
      consec <= 4'h0;
    end
    else if (meas_ok && meas.last)
    begin
      cycle_bad <= 1'b0;
      if (cycle_bad || over_high || under_low)
        consec <= (consec == 4'hF) ? consec : consec + 4'h1;
      else
        consec <= 4'h0;
    end
    else if (meas_ok && (over_high || under_low))
      cycle_bad <= 1'b1;
  end

  // R04 R20 maskable warning; R02 critical ignores every mask
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      warn_active <= 1'b0;
      maskable_warning_oe <= 1'b0;
      crit_oe <= 1'b0;
    end
    else
    begin
      warn_active <= (consec > {1'b0, consec_limit}) && (|high_stat || |low_stat);
      maskable_warning_oe <= warn_active && !mask_all;
      crit_oe <= |crit_hot;
    end
  end

  chk_crit_set_pin: assert property (@(posedge clk) disable iff (rst) // R01
    meas_ok && at_crit |-> ##2 crit_oe)
    else $error("critical pin not asserted after result reached limit");
  chk_crit_no_mask: assert property (@(posedge clk) disable iff (rst) // R02
    $rose(|crit_hot) && mask_all |=> crit_oe)
    else $error("critical pin suppressed by mask");
  chk_high_status: assert property (@(posedge clk) disable iff (rst) // R05
    meas_ok && over_high |=> high_stat[$past(meas.chan)])
    else $error("high status not set");
  chk_low_status: assert property (@(posedge clk) disable iff (rst) // R06
    meas_ok && under_low |=> low_stat[$past(meas.chan)])
    else $error("low status not set");
  chk_result_low_zero: assert property (@(posedge clk) disable iff (rst) // R08
    rd_sel.kind == K_RES_LO |-> rd_byte[4:0] == 5'h00)
    else $error("result low byte unused bits nonzero");
  chk_default_sat: assert property (@(posedge clk) disable iff (rst) // R11
    meas_ok && !ext_range && meas.temp > 13'sd1023 |=> result[$past(meas.chan)] == 11'h3FF)
    else $error("default range saturation wrong");
  chk_ext_sat: assert property (@(posedge clk) disable iff (rst) // R12
    meas_ok && ext_range && meas.temp < -13'sd512 |=> result[$past(meas.chan)] == 11'h000)
    else $error("extended range low saturation wrong");
  chk_limit_hold: assert property (@(posedge clk) disable iff (rst) // R15
    !next_conv |=> high_act[0] == $past(high_act[0]) && crit_act[0] == $past(crit_act[0]))
    else $error("active limit changed outside conversion start");
  chk_high_clear: assert property (@(posedge clk) disable iff (rst) // R17
    rd_take && rd_addr == REG_HIGH_STAT && !meas_ok |=> high_stat == '0)
    else $error("high status not cleared by read");
  chk_mask_hold: assert property (@(posedge clk) disable iff (rst) // R20
    mask_all [*2] |-> !maskable_warning_oe)
    else $error("warning asserted while masked");
  cov_crit_event: cover property (@(posedge clk) disable iff (rst) $rose(crit_oe));
  cov_warn_event: cover property (@(posedge clk) disable iff (rst) $rose(maskable_warning_oe));
  cov_write_byte: cover property (@(posedge clk) disable iff (rst) wr_stb);
  cov_read_byte: cover property (@(posedge clk) disable iff (rst) rd_take);
endmodule : temp_result_limit_compare

// ==== tb/i2c_host_model.sv ====
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic clk, // system clock
  input wire logic sda_oe, // device pulls data low
  output logic scl, // serial clock level
  output logic sda, // data wire level
  output logic rd_valid, // pulse: read byte ready
  output logic [7:0] rd_data, // byte read back
  output logic addr_ack // address was answered
);
  logic low = 1'b0;
  // pull-up on the data wire: released means high
  assign sda = ~(sda_oe | low);
  initial
  begin
    scl = 1'b1;
    rd_valid = 1'b0;
    rd_data = 8'h00;
    addr_ack = 1'b0;
  end
  task automatic wt();
    repeat (8) @(posedge clk);
  endtask : wt
  task automatic go();
    low <= 1'b0;
    wt();
    scl <= 1'b1;
    wt();
    low <= 1'b1;
    wt();
    scl <= 1'b0;
    wt();
  endtask : go
  task automatic halt();
    low <= 1'b1;
    wt();
    scl <= 1'b1;
    wt();
    low <= 1'b0;
    wt();
  endtask : halt
  task automatic clk_bit(input logic b, output logic r);
    low <= ~b;
    wt();
    scl <= 1'b1;
    wt();
    r = sda;
    scl <= 1'b0;
    wt();
  endtask : clk_bit
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask : put
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
    logic a;
    go();
    put({dev, 1'b0}, a);
    addr_ack <= a;
    put(ptr, a);
    put(d, a);
    halt();
  endtask : wr
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr);
    logic a;
    logic [7:0] d;
    go();
    put({dev, 1'b0}, a);
    put(ptr, a);
    go();
    put({dev, 1'b1}, a);
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, d[i]);
    clk_bit(1'b1, a);
    halt();
    rd_data <= d;
    rd_valid <= 1'b1;
    @(posedge clk);
    rd_valid <= 1'b0;
  endtask : rd
endmodule : i2c_host_model

// ==== tb/temp_result_limit_compare_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, got, exp) \
  total_checks++; \
  if ((got) !== (exp)) \
  begin \
    err_total++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); \
  end
module temp_result_limit_compare_tb_top
  import temp_monitor_pkg::*;
();
  typedef struct {string nm; logic [7:0] v;} note_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strap_en = 1'b0;
  logic [2:0] strap_code = 3'h0;
  logic meas_valid = 1'b0;
  meas_type meas = '0;
  logic scl, sda, sda_oe, rd_valid, addr_ack, conv_start, standby, crit_oe, warn_oe;
  logic [7:0] rd_data;
  wire [2:0] od_val;
  logic [31:0] seed = 32'h7FB9F5FF;
  logic [6:0] dev = DEFAULT_ADDR;
  logic signed [12:0] tv [10] = '{13'h1FF8, 13'h0000, 13'h0001, 13'h0008, 13'h03FF,
    13'h0400, 13'h1E00, 13'h1DFF, 13'h05FF, 13'h0600};
  int err_total = 0;
  int total_checks = 0;
  int starts = 0;
  note_type notes[$];
  note_type cur;
  always #2.5 clk = ~clk;
  temp_result_limit_compare u_temp_result_limit_compare (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(od_val[0]), .sda_oe(sda_oe),
    .addr_strap_en(strap_en), .addr_strap_code(strap_code), .meas_valid(meas_valid),
    .meas(meas), .conv_start(conv_start), .conv_standby(standby), .crit_out(od_val[1]),
    .crit_oe(crit_oe), .maskable_warning_out(od_val[2]), .maskable_warning_oe(warn_oe)
  );
  i2c_host_model u_i2c_host_model (
    .clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda), .rd_valid(rd_valid),
    .rd_data(rd_data), .addr_ack(addr_ack)
  );
  always @(posedge clk)
  begin
    if (rd_valid === 1'b1)
    begin
      cur = notes.pop_front();
      `CHK(cur.nm, rd_data, cur.v)
    end
    if (conv_start === 1'b1)
      starts++;
  end
  task automatic final_report();
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  function automatic logic [10:0] fmt(input int t, input int e);
    int v;
    int top;
    v = e ? t + 512 : t;
    top = e ? 2047 : 1023;
    if (v < 0)
      v = 0;
    if (v > top)
      v = top;
    return 11'(v);
  endfunction : fmt
  task automatic rd(input logic [7:0] ptr, input logic [7:0] v, input string nm);
    notes.push_back('{nm, v});
    u_i2c_host_model.rd(dev, ptr);
  endtask : rd
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    u_i2c_host_model.wr(dev, ptr, d);
  endtask : wr
  task automatic send(input logic [2:0] ch, input logic signed [12:0] t);
    meas_valid <= 1'b1;
    meas <= '{ch, t, 1'b1};
    @(posedge clk);
    meas_valid <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : send
  initial
  begin
    #450000;
    err_total++;
    final_report();
  end
  initial
  begin
    logic [10:0] r;
    logic signed [12:0] t;
    int s0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("crit idle", crit_oe, 1'b0)
    `CHK("pin values", od_val, 3'h0)
    rd(REG_DEVICE_SETUP, SETUP_RESET, "setup");
    rd(REG_HYST, HYST_RESET, "hyst");
    rd(BASE_HIGH_ALIAS, 8'h55, "alias0");
    rd(BASE_CRIT + 8'h04, CRIT_RESET, "crit4");
    wr(BASE_HIGH_ALIAS + 8'h02, 8'h30);
    wr(BASE_LOW_HI + 8'h02, 8'h10);
    rd(BASE_HIGH_HI + 8'h02, 8'h30, "high2");
    rd(BASE_LOW_ALIAS + 8'h02, 8'h10, "low2");
    send(3'h0, 13'h0100);
    send(3'h2, 13'h0080);
    `CHK("warn low", warn_oe, 1'b1)
    rd(REG_LOW_STAT, 8'h04, "lowstat");
    send(3'h2, 13'h0180);
    rd(REG_HIGH_STAT, 8'h00, "high equal");
    send(3'h2, 13'h0181);
    `CHK("warn high", warn_oe, 1'b1)
    wr(REG_DEVICE_SETUP, 8'h80);
    `CHK("warn masked", warn_oe, 1'b0)
    send(3'h3, 13'h02A8);
    `CHK("crit on", crit_oe, 1'b1)
    rd(REG_CRIT_STAT, 8'h08, "critstat");
    rd(REG_STATUS, 8'h12, "status");
    rd(REG_HIGH_STAT, 8'h04, "highstat");
    rd(REG_STATUS, 8'h02, "status");
    send(3'h3, 13'h0258);
    `CHK("crit hold", crit_oe, 1'b1)
    send(3'h3, 13'h0257);
    `CHK("crit off", crit_oe, 1'b0)
    // unmask, then demand two consecutive bad cycles before warning
    wr(REG_DEVICE_SETUP, 8'h00);
    wr(REG_CONSEC, 8'h01);
    rd(REG_CONSEC, 8'h01, "consec");
    send(3'h2, 13'h0181);
    `CHK("warn one bad", warn_oe, 1'b0)
    send(3'h2, 13'h0181);
    `CHK("warn two bad", warn_oe, 1'b1)
    rd(REG_HIGH_STAT, 8'h04, "high again");
    `CHK("warn cleared", warn_oe, 1'b0)
    for (int e = 0; e < 2; e++)
    begin
      wr(REG_DEVICE_SETUP, e ? 8'h04 : 8'h00);
      for (int k = 0; k < 12; k++)
      begin
        seed = xs(seed);
        t = k < 10 ? tv[k] : 13'(seed[11:0]) - 13'h0258;
        r = fmt(t, e);
        send(3'h1, t);
        rd(BASE_RES_HI + 8'h01, r[10:3], "result hi");
        rd(BASE_RES_LO + 8'h01, {r[2:0], 5'h00}, "result lo");
      end
    end
    wr(REG_DEVICE_SETUP, 8'h40);
    `CHK("standby", standby, 1'b1)
    rd(REG_HIGH_STAT, 8'h02, "high ch1");
    wr(BASE_HIGH_HI + 8'h04, 8'h24);
    send(3'h4, 13'h0200);
    rd(REG_HIGH_STAT, 8'h00, "old limit");
    s0 = starts;
    wr(REG_SINGLE_CONV, 8'h00);
    send(3'h4, 13'h0200);
    `CHK("one start", starts - s0, 1)
    rd(REG_HIGH_STAT, 8'h10, "new limit");
    strap_en <= 1'b1;
    strap_code <= 3'h5;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    wr(REG_DEVICE_SETUP, 8'h84);
    `CHK("other address", addr_ack, 1'b0)
    dev = 7'h3C;
    rd(REG_DEVICE_SETUP, 8'h00, "strap address");
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule : temp_result_limit_compare_tb_top
